/* File: verilog/sci_pkg.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose: constants and types shared by the system control instruction unit
// Assumes: 16-bit words, octal opcodes written here in hexadecimal
// Notes:   timing counts derive from the clock rate below
//////////////////////////////////////////////////////////////////////////////
package sci_pkg;

  // opcodes
  localparam logic [15:0] OP_HALT    = 16'h0000;  // octal 000000
  localparam logic [15:0] OP_WAIT    = 16'h0001;  // octal 000001
  localparam logic [15:0] OP_RTI     = 16'h0002;  // octal 000002
  localparam logic [15:0] OP_RESET   = 16'h0005;  // octal 000005
  localparam logic [15:0] OP_RTT     = 16'h0006;  // octal 000006
  localparam logic [10:0] OP_CC_HI   = 11'h005;   // bits 15:5 of octal 000240..000277
  localparam logic [8:0]  OP_MFP     = 9'h035;    // bits 14:6, octal 065
  localparam logic [8:0]  OP_MTP     = 9'h036;    // bits 14:6, octal 066
  localparam logic [9:0]  OP_WRITE_STATUS_BYTE    = 10'h234;   // bits 15:6, octal 1064
  localparam logic [9:0]  OP_READ_STATUS_BYTE    = 10'h237;   // bits 15:6, octal 1067

  // processor_status_word fields
  localparam int PSW_C      = 0;
  localparam int PSW_V      = 1;
  localparam int PSW_Z      = 2;
  localparam int PSW_N      = 3;
  localparam int PSW_T      = 4;
  localparam int PSW_PREV_L = 12;
  localparam int PSW_CUR_L  = 14;
  localparam int CC_SET_BIT = 4;
  localparam logic [15:0] PSW_RST = 16'h0000;
  localparam logic [15:0] SP_RST  = 16'h0000;
  localparam logic [15:0] PC_RST  = 16'h0000;
  localparam logic [15:0] STACK_STEP = 16'h0002;

  // wishbone register offsets (byte addresses)
  localparam logic [7:0] REG_STATUS  = 8'h00;
  localparam logic [7:0] REG_PSW     = 8'h04;
  localparam logic [7:0] REG_SP      = 8'h08;
  localparam logic [7:0] REG_PC      = 8'h0c;
  localparam logic [7:0] REG_HALT_PC = 8'h10;

  // status register fields
  localparam int ST_HALTED = 0;
  localparam int ST_WAIT   = 1;
  localparam int ST_INIT   = 2;
  localparam int ST_BUSY   = 3;

  // bus initialize pulse length
  localparam int INIT_TIME_MS = 100;
  localparam int CLK_MHZ      = 250;
  localparam int INIT_CYC     = INIT_TIME_MS * 1000 * CLK_MHZ;

  // memory cycles per addressing mode
  localparam logic [2:0] SRC_CYC [0:7] = '{3'h0, 3'h1, 3'h1, 3'h2, 3'h1, 3'h2, 3'h2, 3'h3};
  localparam logic [2:0] DST_CYC [0:7] = '{3'h0, 3'h2, 3'h2, 3'h3, 3'h2, 3'h3, 3'h3, 3'h4};
  localparam int MODE7_DST_CORE_NS = 4290;

  // operation kinds for the previous-space and status moves
  localparam logic [1:0] K_MFP  = 2'h0;
  localparam logic [1:0] K_MTP  = 2'h1;
  localparam logic [1:0] K_WRITE_STATUS_BYTE = 2'h2;
  localparam logic [1:0] K_READ_STATUS_BYTE = 2'h3;

  typedef enum logic [3:0] {
    S_IDLE    = 4'h0,
    S_POP_PC  = 4'h1,
    S_POP_PSW = 4'h2,
    S_RD_SRC  = 4'h3,
    S_PUSH    = 4'h4,
    S_POP_TMP = 4'h5,
    S_WR_DST  = 4'h6,
    S_HALT    = 4'h7,
    S_WAIT    = 4'h8,
    S_INIT    = 4'h9
  } sci_state_e;

endpackage : sci_pkg

/* File: verilog/sci_exec.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose: executes processor control instructions of a 16-bit minicomputer
// Assumes: fetch logic supplies the opcode, next pc, effective address and
//          register operand; memory port may hold off its ack for any number of cycles
// Notes:   wishbone slave exposes status, psw, sp, pc and the halt address
//////////////////////////////////////////////////////////////////////////////
//
// The Wishbone interface to the registers and the placing of the registers are this design's own decisions.
module sci_exec
  import sci_pkg::*;
#(
  parameter int unsigned INIT_CYCLES = INIT_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // instruction issue from fetch logic
  input  wire logic        instr_valid_i,
  input  wire logic [15:0] instr_i,
  input  wire logic [15:0] next_pc_i,
  input  wire logic [15:0] opnd_addr_i,
  input  wire logic [15:0] reg_rdata_i,
  output logic             instr_ready_o,
  output logic             done_o,
  output logic             trace_trap_o,
  output logic      [2:0]  src_cycles_o,
  output logic      [2:0]  dst_cycles_o,
  // register file write for mode 0 destinations
  output logic             reg_wr_o,
  output logic      [2:0]  reg_idx_o,
  output logic      [15:0] reg_wdata_o,
  // memory / system bus master port
  output logic             mem_req_o,
  output logic             mem_we_o,
  output logic             mem_byte_o,
  output logic      [1:0]  mem_space_o,
  output logic      [15:0] mem_addr_o,
  output logic      [15:0] mem_wdata_o,
  input  wire logic [15:0] mem_rdata_i,
  input  wire logic        mem_ack_i,
  // pins: interrupt, console, bus initialize
  input  wire logic        irq_i,
  input  wire logic        console_continue_i,
  output logic             irq_ack_o,
  output logic             bus_init_o,
  output logic             halted_o,
  output logic             waiting_o,
  output logic      [15:0] halt_addr_o,
  output logic      [15:0] processor_status_word_o,
  output logic      [15:0] pc_o
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  sci_state_e  state;
  logic [15:0] pc;
  logic [15:0] sp;
  logic [15:0] processor_status_word;
  logic [15:0] temp;
  logic [15:0] ea;
  logic        ea_reg;
  logic [1:0]  kind;
  logic        rtt_r;
  logic [31:0] init_cnt;
  logic        irq_s1;
  logic        irq_s2;
  logic        con_s1;
  logic        con_s2;
  logic        con_s3;

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire         irq_pend   = irq_s2;
  wire         con_rise   = con_s2 & ~con_s3;
  wire [2:0]   mode       = instr_i[5:3];
  wire         mode0      = (mode == 3'h0);
  wire         is_halt    = (instr_i == OP_HALT);
  wire         is_wait    = (instr_i == OP_WAIT);
  wire         is_rti     = (instr_i == OP_RTI);
  wire         is_rtt     = (instr_i == OP_RTT);
  wire         is_reset   = (instr_i == OP_RESET);
  wire         is_cc      = (instr_i[15:5] == OP_CC_HI);
  wire         is_mfp     = (instr_i[14:6] == OP_MFP);
  wire         is_mtp     = (instr_i[14:6] == OP_MTP);
  wire         is_write_status_byte    = (instr_i[15:6] == OP_WRITE_STATUS_BYTE);
  wire         is_read_status_byte    = (instr_i[15:6] == OP_READ_STATUS_BYTE);
  wire         boundary   = (state == S_IDLE) | (state == S_WAIT);
  // interrupts take priority over the next issue at a boundary
  wire         take_irq   = boundary & irq_pend;
  wire         issue      = instr_valid_i & instr_ready_o;
  wire [3:0]   cc_sel     = instr_i[3:0];
  // empty selections fall out as no-operations with no special case
  wire [3:0]   cc_new     = instr_i[CC_SET_BIT] ? (processor_status_word[3:0] | cc_sel)
                                                : (processor_status_word[3:0] & ~cc_sel);
  wire [15:0]  psw_byte   = {{8{processor_status_word[7]}}, processor_status_word[7:0]};
  wire         mem_ok     = mem_req_o & mem_ack_i;
  wire [15:0]  sp_dec     = sp - STACK_STEP;
  wire [15:0]  sp_inc     = sp + STACK_STEP;
  wire         kind_prev  = ((state == S_RD_SRC) & (kind == K_MFP)) |
                            ((state == S_WR_DST) & (kind == K_MTP));

  ////////////////////////////////////////////////////////////////////////////
  // memory port; halt and wait hold no request, so any transfer ends at once
  assign mem_req_o   = (state == S_POP_PC) | (state == S_POP_PSW) | (state == S_RD_SRC) |
                       (state == S_PUSH) | (state == S_POP_TMP) |
                       (state == S_WR_DST);
  assign mem_we_o    = (state == S_PUSH) | (state == S_WR_DST);
  assign mem_byte_o  = (state == S_WR_DST) & (kind == K_READ_STATUS_BYTE);
  assign mem_space_o = kind_prev ? processor_status_word[PSW_PREV_L +: 2] : processor_status_word[PSW_CUR_L +: 2];
  assign mem_addr_o  = (state == S_PUSH) ? sp_dec :
                       ((state == S_RD_SRC) | (state == S_WR_DST)) ? ea : sp;
  assign mem_wdata_o = temp;

  ////////////////////////////////////////////////////////////////////////////
  // handshake and status outputs
  assign instr_ready_o           = (state == S_IDLE) & ~irq_pend;
  assign irq_ack_o               = take_irq;
  assign halted_o                = (state == S_HALT);
  assign waiting_o               = (state == S_WAIT);
  assign bus_init_o              = (state == S_INIT);
  assign halt_addr_o             = pc;
  assign processor_status_word_o = processor_status_word;
  assign pc_o                    = pc;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_s1 <= 1'b0;
      irq_s2 <= 1'b0;
      con_s1 <= 1'b0;
      con_s2 <= 1'b0;
      con_s3 <= 1'b0;
    end else begin
      irq_s1 <= irq_i;
      irq_s2 <= irq_s1;
      con_s1 <= console_continue_i;
      con_s2 <= con_s1;
      con_s3 <= con_s2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave: one wait state, ack drops the cycle after
  wire        wb_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        wb_wr   = wb_req & wb_we_i;
  wire        wr_psw  = wb_wr & (wb_adr_i == REG_PSW);
  wire        wr_sp   = wb_wr & (wb_adr_i == REG_SP);
  wire [15:0] lane_m  = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [15:0] status  = {12'h000, (state != S_IDLE), bus_init_o, waiting_o, halted_o};
  wire [15:0] rd_mux  = (wb_adr_i == REG_STATUS)  ? status :
                        (wb_adr_i == REG_PSW)     ? processor_status_word :
                        (wb_adr_i == REG_SP)      ? sp :
                        (wb_adr_i == REG_PC)      ? pc :
                        (wb_adr_i == REG_HALT_PC) ? pc : 16'h0000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= (wb_req & ~wb_we_i) ? {16'h0000, rd_mux} : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer; an instruction update of psw or sp wins over a bus write
  // in the same cycle, so software should write them while halted
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state        <= S_IDLE;
      pc           <= PC_RST;
      sp           <= SP_RST;
      processor_status_word          <= PSW_RST;
      temp         <= 16'h0000;
      ea           <= 16'h0000;
      ea_reg       <= 1'b0;
      kind         <= K_MFP;
      rtt_r        <= 1'b0;
      init_cnt     <= 32'h0000_0000;
      done_o       <= 1'b0;
      trace_trap_o <= 1'b0;
      src_cycles_o <= 3'h0;
      dst_cycles_o <= 3'h0;
      reg_wr_o     <= 1'b0;
      reg_idx_o    <= 3'h0;
      reg_wdata_o  <= 16'h0000;
    end else begin
      done_o       <= 1'b0;
      trace_trap_o <= 1'b0;
      reg_wr_o     <= 1'b0;
      if (wr_psw) begin
        processor_status_word <= (processor_status_word & ~lane_m) | (wb_dat_i[15:0] & lane_m);
      end
      if (wr_sp) begin
        sp <= (sp & ~lane_m) | (wb_dat_i[15:0] & lane_m);
      end
      case (state)
        S_IDLE: begin
          if (issue) begin
            pc           <= next_pc_i;
            ea           <= opnd_addr_i;
            ea_reg       <= mode0;
            reg_idx_o    <= instr_i[2:0];
            rtt_r        <= is_rtt;
            src_cycles_o <= SRC_CYC[mode];
            dst_cycles_o <= DST_CYC[mode];
            if (is_halt) begin
              state <= S_HALT;
            end else if (is_wait) begin
              state <= S_WAIT;
            end else if (is_rti | is_rtt) begin
              state <= S_POP_PC;
            end else if (is_reset) begin
              init_cnt <= 32'h0000_0000;
              state    <= S_INIT;
            end else if (is_cc) begin
              processor_status_word[3:0]     <= cc_new;
              done_o       <= 1'b1;
              trace_trap_o <= processor_status_word[PSW_T];
            end else if (is_mfp) begin
              kind <= K_MFP;
              if (mode0) begin
                temp  <= reg_rdata_i;
                state <= S_PUSH;
              end else begin
                state <= S_RD_SRC;
              end
            end else if (is_mtp) begin
              kind  <= K_MTP;
              state <= S_POP_TMP;
            end else if (is_write_status_byte) begin
              // no privilege check: user mode may run status moves
              kind <= K_WRITE_STATUS_BYTE;
              if (mode0) begin
                processor_status_word[7:0]     <= reg_rdata_i[7:0];
                done_o       <= 1'b1;
                trace_trap_o <= processor_status_word[PSW_T];
              end else begin
                state <= S_RD_SRC;
              end
            end else if (is_read_status_byte) begin
              kind       <= K_READ_STATUS_BYTE;
              temp       <= psw_byte;
              processor_status_word[PSW_N] <= processor_status_word[7];
              processor_status_word[PSW_Z] <= (processor_status_word[7:0] == 8'h00);
              processor_status_word[PSW_V] <= 1'b0;
              if (mode0) begin
                reg_wr_o     <= 1'b1;
                reg_wdata_o  <= psw_byte;
                done_o       <= 1'b1;
                trace_trap_o <= processor_status_word[PSW_T];
              end else begin
                state <= S_WR_DST;
              end
            end else begin
              // anything else belongs to other units; retire it quietly
              done_o <= 1'b1;
            end
          end
        end
        S_POP_PC: begin
          if (mem_ok) begin
            pc    <= mem_rdata_i;
            sp    <= sp_inc;
            state <= S_POP_PSW;
          end
        end
        S_POP_PSW: begin
          if (mem_ok) begin
            processor_status_word          <= mem_rdata_i;
            sp           <= sp_inc;
            done_o       <= 1'b1;
            trace_trap_o <= mem_rdata_i[PSW_T] & ~rtt_r;
            state        <= S_IDLE;
          end
        end
        S_RD_SRC: begin
          if (mem_ok) begin
            if (kind == K_WRITE_STATUS_BYTE) begin
              processor_status_word[7:0]     <= mem_rdata_i[7:0];
              done_o       <= 1'b1;
              trace_trap_o <= processor_status_word[PSW_T];
              state        <= S_IDLE;
            end else begin
              temp  <= mem_rdata_i;
              state <= S_PUSH;
            end
          end
        end
        S_PUSH: begin
          if (mem_ok) begin
            sp           <= sp_dec;
            processor_status_word[PSW_N]   <= temp[15];
            processor_status_word[PSW_Z]   <= (temp == 16'h0000);
            processor_status_word[PSW_V]   <= 1'b0;
            done_o       <= 1'b1;
            trace_trap_o <= processor_status_word[PSW_T];
            state        <= S_IDLE;
          end
        end
        S_POP_TMP: begin
          if (mem_ok) begin
            temp       <= mem_rdata_i;
            sp         <= sp_inc;
            processor_status_word[PSW_N] <= mem_rdata_i[15];
            processor_status_word[PSW_Z] <= (mem_rdata_i == 16'h0000);
            processor_status_word[PSW_V] <= 1'b0;
            if (ea_reg) begin
              reg_wr_o     <= 1'b1;
              reg_wdata_o  <= mem_rdata_i;
              done_o       <= 1'b1;
              trace_trap_o <= processor_status_word[PSW_T];
              state        <= S_IDLE;
            end else begin
              state <= S_WR_DST;
            end
          end
        end
        S_WR_DST: begin
          if (mem_ok) begin
            done_o       <= 1'b1;
            trace_trap_o <= processor_status_word[PSW_T];
            state        <= S_IDLE;
          end
        end
        S_HALT: begin
          if (con_rise) begin
            state <= S_IDLE;
          end
        end
        S_WAIT: begin
          if (irq_pend) begin
            done_o <= 1'b1;
            state  <= S_IDLE;
          end
        end
        S_INIT: begin
          if (init_cnt >= INIT_CYCLES - 1) begin
            done_o <= 1'b1;
            state  <= S_IDLE;
          end else begin
            init_cnt <= init_cnt + 32'h0000_0001;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

endmodule // sci_exec

/* File: test/sci_exec_properties.sv */
////////////////////////////////////////
// Purpose: port checks of the system control instruction unit
// Assumes: one clock, synchronous active high reset
// Notes:   bound to sci_exec from the testbench top file
////////////////////////////////////////
module sci_exec_properties
  import sci_pkg::*;
#(
  parameter int unsigned INIT_CYCLES = 20
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        instr_valid_i,
  input wire logic [15:0] instr_i,
  input wire logic [15:0] next_pc_i,
  input wire logic        instr_ready_o,
  input wire logic        done_o,
  input wire logic        trace_trap_o,
  input wire logic        mem_req_o,
  input wire logic        mem_we_o,
  input wire logic        irq_ack_o,
  input wire logic        bus_init_o,
  input wire logic        halted_o,
  input wire logic        waiting_o,
  input wire logic [15:0] halt_addr_o,
  input wire logic [15:0] processor_status_word_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic        take;
  logic [15:0] op_q, ps_q, npc_q;
  int unsigned init_cnt;
  assign take = instr_valid_i && instr_ready_o;
  // snapshot at issue so the checks compare against pre-instruction state
  always_ff @(posedge clk_i) begin
    init_cnt <= (rst_i || !bus_init_o) ? 0 : init_cnt + 1;
    if (take) begin
      op_q  <= instr_i;
      ps_q  <= processor_status_word_o;
      npc_q <= next_pc_i;
    end
  end
  wb_ack_time_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("register bus ack late");
  wb_ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("register bus ack too long");
  rti_pop_a: assert property (
    take && instr_i == OP_RTI |=> mem_req_o && !mem_we_o)
    else $error("return did not start with a stack read");
  trace_done_a: assert property (trace_trap_o |-> done_o)
    else $error("trace trap away from retirement");
  flag_op_a: assert property (
    take && instr_i[15:5] == OP_CC_HI |=> done_o && processor_status_word_o[3:0] ==
      (op_q[4] ? ps_q[3:0] | op_q[3:0] : ps_q[3:0] & ~op_q[3:0]))
    else $error("flag operator result wrong");
  halt_stop_a: assert property (
    take && instr_i == OP_HALT |=> halted_o && halt_addr_o == npc_q)
    else $error("halt address wrong");
  halt_quiet_a: assert property (
    halted_o |-> !mem_req_o && !bus_init_o && !done_o)
    else $error("bus activity while halted");
  wait_idle_a: assert property (waiting_o |-> !mem_req_o)
    else $error("bus used while waiting");
  irq_bound_a: assert property (
    irq_ack_o |-> !mem_req_o && !halted_o && !bus_init_o)
    else $error("interrupt taken inside an instruction");
  init_len_a: assert property ($fell(bus_init_o) |-> init_cnt == INIT_CYCLES)
    else $error("bus initialize length wrong");
  cov_flag: cover property (take && instr_i[15:5] == OP_CC_HI);
  cov_halt: cover property (halted_o);
  cov_init: cover property ($rose(bus_init_o));
  cov_trace: cover property (trace_trap_o);
endmodule // sci_exec_properties

/* File: test/sci_mem_model.sv */
////////////////////////////////////////
// Purpose: system bus memory answering the unit's memory port
// Assumes: word addressed by addr bits 7:1, 128 words
// Notes:   slow_i adds three wait cycles before ack
////////////////////////////////////////
module sci_mem_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic        slow_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [15:0] wdata_i,
  output logic      [15:0] rdata_o,
  output logic             ack_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] ram [0:127];
  logic [1:0]  wait_cnt;
  // read data toggles outside an ack or a slow wait so a stale word never looks valid;
  // plain always so the bench may preload ram between transfers
  always @(posedge clk_i) begin
    if (rst_i || ack_o || !req_i) begin
      ack_o    <= 1'b0;
      wait_cnt <= 2'h0;
      rdata_o  <= ~rdata_o;
    end else if (!slow_i || wait_cnt == 2'h3) begin
      ack_o   <= 1'b1;
      rdata_o <= ram[addr_i[7:1]];
      if (we_i) ram[addr_i[7:1]] <= wdata_i;
    end else begin
      wait_cnt <= wait_cnt + 2'h1;
    end
  end
endmodule // sci_mem_model

/* File: test/test_sci_exec.sv */
////////////////////////////////////////
// Purpose: self-checking bench of the system control instruction unit
// Assumes: bus initialize shortened to 20 cycles
// Notes:   done pulses are matched against a queue of expectations
////////////////////////////////////////
module test_sci_exec
  import sci_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned INIT_CYCLES = 20;
  typedef struct {logic [15:0] ps; logic tr; logic [16:0] rw; logic [5:0] cyc;} sci_exp_s;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, instr_valid_i = 0;
  logic irq_i = 0, console_continue_i = 0, slow = 0, mem_ack_i;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic [15:0] instr_i = 16'h0, next_pc_i = 16'h0, opnd_addr_i = 16'h0, reg_rdata_i = 16'h0;
  logic wb_ack_o, instr_ready_o, done_o, trace_trap_o, reg_wr_o, mem_req_o, mem_we_o;
  logic mem_byte_o, irq_ack_o, bus_init_o, halted_o, waiting_o;
  logic [2:0] src_cycles_o, dst_cycles_o, reg_idx_o;
  logic [1:0] mem_space_o;
  logic [15:0] reg_wdata_o, mem_addr_o, mem_wdata_o, mem_rdata_i, halt_addr_o, pc_o;
  logic [15:0] processor_status_word_o, ps, q, op;
  logic [2:0] srcc [8] = '{3'h0, 3'h1, 3'h1, 3'h2, 3'h1, 3'h2, 3'h2, 3'h3};
  logic [2:0] dstc [8] = '{3'h0, 3'h2, 3'h2, 3'h3, 3'h2, 3'h3, 3'h3, 3'h4};
  sci_exp_s expq [$];
  sci_exp_s got_e;
  int n_errors = 0, num_checks = 0;
  sci_exec #(.INIT_CYCLES(INIT_CYCLES)) uut (.*);
  sci_mem_model mem (.clk_i, .rst_i, .req_i(mem_req_o), .we_i(mem_we_o), .slow_i(slow),
    .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i), .ack_o(mem_ack_i));
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  ////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'h3;
    wb_dat_i <= {16'h0, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o[15:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // expected psw is the bench's running model in ps, set by the caller
  task automatic issue(input logic [15:0] o, ea, rd, input logic tr, input logic [16:0] rw);
    sci_exp_s e;
    e = '{ps, tr, rw, {srcc[o[5:3]], dstc[o[5:3]]}};
    if (o != OP_HALT) expq.push_back(e);
    @(posedge clk_i);
    instr_valid_i <= 1'b1;
    instr_i       <= o;
    opnd_addr_i   <= ea;
    reg_rdata_i   <= rd;
    next_pc_i     <= 16'($urandom) & 16'hfffe;
    slow          <= 1'($urandom);
    do @(posedge clk_i); while (instr_ready_o !== 1'b1);
    instr_valid_i <= 1'b0;
  endtask
  always @(posedge clk_i) begin
    if (done_o === 1'b1) begin
      got_e = expq.pop_front();
      chk(processor_status_word_o, got_e.ps, "psw");
      chk(16'(trace_trap_o), 16'(got_e.tr), "trace");
      chk(16'({src_cycles_o, dst_cycles_o}), 16'(got_e.cyc), "cycles");
      chk(16'(reg_wr_o), 16'(got_e.rw[16]), "reg write");
      if (got_e.rw[16]) chk(reg_wdata_o, got_e.rw[15:0], "reg");
    end
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    $display("wrong value at %0t: timeout", $time);
    end_sim();
  end
  ////////////////////////////////////////
  initial begin
    void'($urandom(32'hbd431dd6));
    ps = 16'h0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b1, REG_PC, 16'hffff);
    for (int i = 0; i < 4; i++) begin
      wb(1'b0, 8'(4 * i + 4) == 8'h10 ? 8'h14 : 8'(4 * i + 4), 16'h0);
      chk(q, 16'h0, "reset value");
    end
    $display("test registers done");
    for (int i = 0; i < 15; i++) begin
      op = i < 3 ? {8'h0, i == 0 ? 8'ha0 : i == 1 ? 8'hb0 : 8'hbf} : {11'h005, 5'($urandom)};
      ps[3:0] = op[4] ? ps[3:0] | op[3:0] : ps[3:0] & ~op[3:0];
      issue(op, 16'h0, 16'h0, 1'b0, 17'h0);
    end
    for (int m = 0; m < 8; m++) issue(16'h1000 | 16'(m << 3), 16'h0, 16'h0, 1'b0, 17'h0);
    $display("test flags and cycles done");
    for (int i = 0; i < 3; i++) begin
      q = i == 0 ? 16'h0 : 16'($urandom) & 16'h00ef;
      ps = {ps[15:8], q[7:0]};
      issue(16'h8d00, 16'h0, q, 1'b0, 17'h0);
      // the byte copied out is the status before the move's own flag update
      op = {{8{ps[7]}}, ps[7:0]};
      ps[3:0] = {ps[7], ~|ps[7:0], 1'b0, ps[0]};
      issue(16'h8dc3, 16'h0, 16'h0, 1'b0, {1'b1, op});
    end
    $display("test status moves done");
    mem.ram[8'h20] = 16'h1234;
    mem.ram[8'h21] = 16'h001f;
    mem.ram[8'h08] = 16'h8000;
    wb(1'b1, REG_SP, 16'h0040);
    ps = 16'h001f;
    issue(OP_RTI, 16'h0, 16'h0, 1'b1, 17'h0);
    wait (expq.size() == 0);
    chk(pc_o, 16'h1234, "pc");
    wb(1'b1, REG_SP, 16'h0040);
    issue(OP_RTT, 16'h0, 16'h0, 1'b0, 17'h0);
    ps = 16'h0;
    issue(16'h8d00, 16'h0, 16'h0, 1'b1, 17'h0);
    ps = 16'h0008;
    issue(16'h0d48, 16'h0010, 16'h0, 1'b0, 17'h0);
    wait (expq.size() == 0);
    chk(mem.ram[8'h21], 16'h8000, "pushed word");
    wb(1'b0, REG_SP, 16'h0);
    chk(q, 16'h0042, "stack pointer");
    issue(16'h0d88, 16'h0030, 16'h0, 1'b0, 17'h0);
    wait (expq.size() == 0);
    chk(mem.ram[8'h18], 16'h8000, "stored word");
    $display("test returns and previous space done");
    issue(OP_RESET, 16'h0, 16'h0, 1'b0, 17'h0);
    issue(OP_WAIT, 16'h0, 16'h0, 1'b0, 17'h0);
    repeat (5) @(posedge clk_i);
    chk(16'(waiting_o), 16'h1, "waiting");
    chk(pc_o, next_pc_i, "wait pc");
    irq_i <= 1'b1;
    do @(posedge clk_i); while (irq_ack_o !== 1'b1);
    irq_i <= 1'b0;
    $display("test reset and wait done");
    issue(OP_HALT, 16'h0, 16'h0, 1'b0, 17'h0);
    repeat (3) @(posedge clk_i);
    chk(16'(halted_o), 16'h1, "halted");
    chk(halt_addr_o, next_pc_i, "halt address");
    console_continue_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    console_continue_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk(16'(halted_o), 16'h0, "resumed");
    ps[3:0] = 4'hf;
    issue(16'h00bf, 16'h0, 16'h0, 1'b0, 17'h0);
    wait (expq.size() == 0);
    $display("test halt done");
    end_sim();
  end
endmodule // test_sci_exec

bind sci_exec sci_exec_properties #(.INIT_CYCLES(INIT_CYCLES)) u_chk (.*);
